// ### pkg/adc_readout_pkg.sv
// Purpose: shared constants and types of the dual converter serial readout
// Assumes: one 40 MHz system clock; serial pins are sampled, not clocked on
// Notes:   bit positions count from the frame msb (15) down to the lsb (0)
//
// How it works
// - select fall holds, samples, converts, drives lines
// - sixteen serial clocks complete one conversion
// - track again at rise after 13 falls
// - select rise aborts conversion, floats both lines
// - line a carries converter b frame next
// - line b carries converter a frame next
// - extended read floats at 32nd rise
// - select fall gives zero, falls shift onward
// - last bit shifted out on fifteenth fall
// - frame bit 15 is always zero
// - bit 14 gives span pin from previous transfer
// - bit 13 gives converted channel
// - bit 12 gives converter identity
// - status bits precede their own result
// - early select rise enters power-down modes
// - select held past tenth fall wakes device
package adc_readout_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // frame layout
   localparam int FRAME_BITS    = 16;     // one converter frame
   localparam int RESULT_BITS   = 12;     // conversion result width
   localparam int ZERO_POS      = 15;     // leading zero
   localparam int SPAN_POS      = 14;     // input span status bit
   localparam int CHANNEL_POS   = 13;     // converted channel status bit
   localparam int CONV_ID_POS   = 12;     // converter identity status bit
   localparam int STATUS_EDGES  = 3;      // falls that carry status bits

   // converter identity codes as reported in the frame
   localparam logic CONV_ID_A   = 1'h0;
   localparam logic CONV_ID_B   = 1'h1;

   ////////////////////////////////////////////////////////////////////////////
   // serial clock edge counts
   localparam logic [5:0] TRACK_FALLS   = 6'h0d;  // falls before track return
   localparam logic [5:0] FRAME_FALLS   = 6'h10;  // falls in one frame
   localparam logic [5:0] LAST_OWN_FALL = 6'h0f;  // own frame lsb goes out here
   localparam logic [5:0] EXT_RISES     = 6'h20;  // rise that floats the line
   localparam logic [5:0] PD_FIRST_FALL = 6'h02;  // earliest power-down rise
   localparam logic [5:0] PD_LAST_FALL  = 6'h09;  // latest falls seen for it
   localparam logic [5:0] WAKE_FALLS    = 6'h0a;  // falls that wake the part

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [3:0] PIN_RESET     = 4'h1;   // select idles high
   localparam logic       SPAN_RESET    = 1'h0;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      PWR_NORMAL,
      PWR_PARTIAL,
      PWR_FULL
   } power_state_e;

   // the four sampled pins, in synchroniser bit order
   typedef struct packed {
      logic channel;  // converted channel pin
      logic span;     // input span select pin
      logic sclk;     // serial clock
      logic cs_n;     // chip select, active low
   } pins_s;

   // status field carried behind the leading zero
   typedef struct packed {
      logic span;
      logic channel;
      logic conv_id;
   } status_s;

endpackage

// ### logic/pin_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous pins
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module pin_sync #(
   parameter int               WIDTH       = 4,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             i_clock,
   input  wire logic             i_sys_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] stage1_reg;   // metastable stage, read by stage2 only
   logic [WIDTH-1:0] stage1_next;
   logic [WIDTH-1:0] stage2_reg;   // settled copy
   logic [WIDTH-1:0] stage2_next;

   ////////////////////////////////////////////////////////////////////////////
   // next values
   always_comb begin
      stage1_next = i_async;
      stage2_next = stage1_reg;
   end

   // registers, reset to the idle level of the pins
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         stage1_reg <= RESET_VALUE;
         stage2_reg <= RESET_VALUE;
      end else begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign o_sync = stage2_reg;

endmodule

// ### logic/frame_shifter.sv
// Purpose: builds and shifts the frame of one serial data output
// Assumes: i_shift pulses once per serial clock fall, with i_fall_count
//          already holding the new count of falls
// Notes:   output enable is low while the line is driven
`timescale 1ns/100ps
module frame_shifter #(
   parameter int FRAME_BITS = adc_readout_pkg::FRAME_BITS
) (
   input  wire logic                          i_clock,
   input  wire logic                          i_sys_rst,
   input  wire logic                          i_start,      // select fall
   input  wire adc_readout_pkg::status_s      i_status,     // status at start
   input  wire logic                          i_shift,      // serial fall
   input  wire logic [5:0]                    i_fall_count, // falls so far
   input  wire logic                          i_decision,   // current sar bit
   input  wire logic [FRAME_BITS-1:0]         i_other_frame,
   input  wire logic                          i_release,    // float the line
   output logic      [FRAME_BITS-1:0]         o_frame,
   output logic                               o_serial,
   output logic                               o_oe_n
);

   logic [FRAME_BITS-1:0] frame_reg;   // own frame, filled during conversion
   logic [FRAME_BITS-1:0] frame_next;
   logic                  serial_reg;  // bit on the line
   logic                  serial_next;
   logic                  oe_n_reg;    // low while driving
   logic                  oe_n_next;
   logic [3:0]            pos;         // frame position of the new bit

   ////////////////////////////////////////////////////////////////////////////
   // next values; the same position formula serves both halves of a
   // 32-clock read because it uses only the low four bits of the count
   always_comb begin
      frame_next  = frame_reg;
      serial_next = serial_reg;
      oe_n_next   = oe_n_reg;
      pos         = 4'hf - i_fall_count[3:0];
      if (i_start) begin
         // leading zero and status ahead of the result
         frame_next = '0;
         frame_next[adc_readout_pkg::SPAN_POS]    = i_status.span;
         frame_next[adc_readout_pkg::CHANNEL_POS] = i_status.channel;
         frame_next[adc_readout_pkg::CONV_ID_POS] = i_status.conv_id;
         serial_next = 1'h0;
         oe_n_next   = 1'h0;
      end else if (i_release) begin
         oe_n_next = 1'h1;
      end else if (i_shift && !oe_n_reg) begin
         if (i_fall_count <= 6'(adc_readout_pkg::STATUS_EDGES)) begin
            // status bits directly behind the zero
            serial_next = frame_reg[pos];
         end else if (i_fall_count <= adc_readout_pkg::LAST_OWN_FALL) begin
            // result msb first, lsb on the fifteenth fall
            frame_next[pos] = i_decision;
            serial_next     = i_decision;
         end else begin
            // the other converter's completed frame
            serial_next = i_other_frame[pos];
         end
      end
   end

   // registers
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         frame_reg  <= '0;
         serial_reg <= 1'h0;
         oe_n_reg   <= 1'h1;
      end else begin
         frame_reg  <= frame_next;
         serial_reg <= serial_next;
         oe_n_reg   <= oe_n_next;
      end
   end

   assign o_frame  = frame_reg;
   assign o_serial = serial_reg;
   assign o_oe_n   = oe_n_reg;

endmodule

// ### logic/dual_adc_serial_readout.sv
// Purpose: serial conversion and readout control of a dual converter
// Assumes: select, serial clock, span and channel pins are asynchronous and
//          much slower than i_clock; comparator bits come from same-clock logic
// Notes:   the serial clock is oversampled, so each pin edge is seen two
//          to three system cycles late
`timescale 1ns/100ps
module dual_adc_serial_readout (
   input  wire logic                        i_clock,
   input  wire logic                        i_sys_rst,
   input  wire logic                        i_cs_n,          // chip select
   input  wire logic                        i_sclk,          // serial clock
   input  wire logic                        i_span_sel,      // input span pin
   input  wire logic                        i_channel_flag,  // channel pin
   input  wire logic                        i_decision_a,    // sar bit, conv a
   input  wire logic                        i_decision_b,    // sar bit, conv b
   output logic                             o_serial_out_a,
   output logic                             o_serial_out_a_oe_n,
   output logic                             o_serial_out_b,
   output logic                             o_serial_out_b_oe_n,
   output logic                             o_hold,          // track-and-hold
   output logic                             o_conv_start,    // sample strobe
   output logic                             o_conv_abort,    // abort strobe
   output logic                             o_conv_busy,     // converting
   output logic                             o_sar_step,      // decide strobe
   output adc_readout_pkg::power_state_e    o_power_state
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   adc_readout_pkg::pins_s pins_async;  // raw pins in struct order
   adc_readout_pkg::pins_s pins;        // settled pins

   assign pins_async = '{channel: i_channel_flag, span: i_span_sel,
                         sclk: i_sclk, cs_n: i_cs_n};

   pin_sync #(
      .WIDTH       (4),
      .RESET_VALUE (adc_readout_pkg::PIN_RESET)
   ) u_pin_sync (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_async   (pins_async),
      .o_sync    (pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   // edge detection on the settled pins

   logic cs_n_prev_reg;   // last select level
   logic cs_n_prev_next;
   logic sclk_prev_reg;   // last serial clock level
   logic sclk_prev_next;
   logic cs_fall;         // transfer begins
   logic cs_rise;         // transfer ends
   logic sclk_fall;       // serial fall inside a transfer
   logic sclk_rise;       // serial rise inside a transfer

   // next values of the edge history
   always_comb begin
      cs_n_prev_next = pins.cs_n;
      sclk_prev_next = pins.sclk;
   end

   // edge history registers; select idles high
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         cs_n_prev_reg <= 1'h1;
         sclk_prev_reg <= 1'h0;
      end else begin
         cs_n_prev_reg <= cs_n_prev_next;
         sclk_prev_reg <= sclk_prev_next;
      end
   end

   // serial edges count only while select is low and was low before;
   // a clock edge in the select-fall cycle is not counted, which keeps the
   // leading zero in place for hosts that toggle too early
   assign cs_fall   = cs_n_prev_reg && !pins.cs_n;
   assign cs_rise   = !cs_n_prev_reg && pins.cs_n;
   assign sclk_fall = !cs_n_prev_reg && !pins.cs_n && sclk_prev_reg && !pins.sclk;
   assign sclk_rise = !cs_n_prev_reg && !pins.cs_n && !sclk_prev_reg && pins.sclk;

   ////////////////////////////////////////////////////////////////////////////
   // transfer sequencing: edge counts, track-and-hold, conversion flags

   logic [5:0] fall_cnt_reg;      // serial falls since select fall
   logic [5:0] fall_cnt_next;
   logic [5:0] rise_cnt_reg;      // serial rises since select fall
   logic [5:0] rise_cnt_next;
   logic       hold_reg;          // track-and-hold in hold
   logic       hold_next;
   logic       busy_reg;          // conversion in progress
   logic       busy_next;
   logic       start_reg;         // one-cycle conversion start
   logic       start_next;
   logic       abort_reg;         // one-cycle abort
   logic       abort_next;
   logic       step_reg;          // one-cycle sar decision request
   logic       step_next;
   logic       ext_release;       // 32nd rise floats the line
   logic       line_release;      // any reason to float both lines

   // counts saturate so that a host clocking on past 63 does no harm;
   // the hold flag is cleared on the rise after the thirteenth fall
   always_comb begin
      fall_cnt_next = fall_cnt_reg;
      rise_cnt_next = rise_cnt_reg;
      hold_next     = hold_reg;
      busy_next     = busy_reg;
      start_next    = 1'h0;
      abort_next    = 1'h0;
      step_next     = 1'h0;
      if (cs_fall) begin
         // sample both inputs and start converting
         fall_cnt_next = '0;
         rise_cnt_next = '0;
         hold_next     = 1'h1;
         busy_next     = 1'h1;
         start_next    = 1'h1;
      end else if (cs_rise) begin
         // conversion cut short if still running
         abort_next = busy_reg;
         busy_next  = 1'h0;
         hold_next  = 1'h0;
      end else begin
         if (sclk_fall && fall_cnt_reg != 6'h3f) begin
            fall_cnt_next = fall_cnt_reg + 6'h01;
            // result decisions run while the result bits are due
            step_next = busy_reg &&
                        fall_cnt_reg >= 6'(adc_readout_pkg::STATUS_EDGES) &&
                        fall_cnt_reg <  adc_readout_pkg::LAST_OWN_FALL;
            // sixteenth fall ends the conversion
            if (fall_cnt_next == adc_readout_pkg::FRAME_FALLS) begin
               busy_next = 1'h0;
            end
         end
         if (sclk_rise && rise_cnt_reg != 6'h3f) begin
            rise_cnt_next = rise_cnt_reg + 6'h01;
            if (fall_cnt_reg >= adc_readout_pkg::TRACK_FALLS) begin
               hold_next = 1'h0;
            end
         end
      end
   end

   // sequencing registers
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         fall_cnt_reg <= '0;
         rise_cnt_reg <= '0;
         hold_reg     <= 1'h0;
         busy_reg     <= 1'h0;
         start_reg    <= 1'h0;
         abort_reg    <= 1'h0;
         step_reg     <= 1'h0;
      end else begin
         fall_cnt_reg <= fall_cnt_next;
         rise_cnt_reg <= rise_cnt_next;
         hold_reg     <= hold_next;
         busy_reg     <= busy_next;
         start_reg    <= start_next;
         abort_reg    <= abort_next;
         step_reg     <= step_next;
      end
   end

   // first of the 32nd rise or select rise floats both lines
   assign ext_release  = sclk_rise &&
                         rise_cnt_reg == adc_readout_pkg::EXT_RISES - 6'h01;
   assign line_release = cs_rise || ext_release;

   ////////////////////////////////////////////////////////////////////////////
   // status capture: the span bit reports the pin as it stood at the
   // previous select fall, so the current level is kept for the next one

   logic                      span_last_reg;   // span at previous select fall
   logic                      span_last_next;
   adc_readout_pkg::status_s  status_a;        // status field of converter a
   adc_readout_pkg::status_s  status_b;        // status field of converter b

   // span history advances only on a select fall
   always_comb begin
      span_last_next = span_last_reg;
      if (cs_fall) begin
         span_last_next = pins.span;
      end
   end

   // span history register
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         span_last_reg <= adc_readout_pkg::SPAN_RESET;
      end else begin
         span_last_reg <= span_last_next;
      end
   end

   // both converters share span and channel, differ only in identity
   assign status_a = '{span: span_last_reg, channel: pins.channel,
                       conv_id: adc_readout_pkg::CONV_ID_A};
   assign status_b = '{span: span_last_reg, channel: pins.channel,
                       conv_id: adc_readout_pkg::CONV_ID_B};

   ////////////////////////////////////////////////////////////////////////////
   // data lines: each line carries its own frame, then the other's frame

   logic [adc_readout_pkg::FRAME_BITS-1:0] frame_a;  // converter a frame
   logic [adc_readout_pkg::FRAME_BITS-1:0] frame_b;  // converter b frame

   frame_shifter u_line_a (
      .i_clock       (i_clock),
      .i_sys_rst     (i_sys_rst),
      .i_start       (cs_fall),
      .i_status      (status_a),
      .i_shift       (sclk_fall),
      .i_fall_count  (fall_cnt_next),
      .i_decision    (i_decision_a),
      .i_other_frame (frame_b),
      .i_release     (line_release),
      .o_frame       (frame_a),
      .o_serial      (o_serial_out_a),
      .o_oe_n        (o_serial_out_a_oe_n)
   );

   frame_shifter u_line_b (
      .i_clock       (i_clock),
      .i_sys_rst     (i_sys_rst),
      .i_start       (cs_fall),
      .i_status      (status_b),
      .i_shift       (sclk_fall),
      .i_fall_count  (fall_cnt_next),
      .i_decision    (i_decision_b),
      .i_other_frame (frame_a),
      .i_release     (line_release),
      .o_frame       (frame_b),
      .o_serial      (o_serial_out_b),
      .o_oe_n        (o_serial_out_b_oe_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // power mode: an early select rise powers down, a second one in a row
   // goes all the way; a transfer that outlasts the wake count powers up

   adc_readout_pkg::power_state_e power_reg;   // current power mode
   adc_readout_pkg::power_state_e power_next;
   logic                          early_rise;  // rise inside the window

   assign early_rise = cs_rise &&
                       fall_cnt_reg >= adc_readout_pkg::PD_FIRST_FALL &&
                       fall_cnt_reg <= adc_readout_pkg::PD_LAST_FALL;

   // the wake decision is taken on the tenth fall itself, not at the later
   // select rise, so a host that stops clocking there still wakes the part
   always_comb begin
      power_next = power_reg;
      unique case (power_reg)
         adc_readout_pkg::PWR_NORMAL: begin
            if (early_rise) begin
               power_next = adc_readout_pkg::PWR_PARTIAL;
            end
         end
         adc_readout_pkg::PWR_PARTIAL: begin
            if (early_rise) begin
               power_next = adc_readout_pkg::PWR_FULL;
            end else if (sclk_fall &&
                         fall_cnt_next == adc_readout_pkg::WAKE_FALLS) begin
               power_next = adc_readout_pkg::PWR_NORMAL;
            end
         end
         adc_readout_pkg::PWR_FULL: begin
            if (sclk_fall && fall_cnt_next == adc_readout_pkg::WAKE_FALLS) begin
               power_next = adc_readout_pkg::PWR_NORMAL;
            end
         end
         default: begin
            power_next = adc_readout_pkg::PWR_NORMAL;
         end
      endcase
   end

   // power mode register
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         power_reg <= adc_readout_pkg::PWR_NORMAL;
      end else begin
         power_reg <= power_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs

   assign o_hold        = hold_reg;
   assign o_conv_start  = start_reg;
   assign o_conv_abort  = abort_reg;
   assign o_conv_busy   = busy_reg;
   assign o_sar_step    = step_reg;
   assign o_power_state = power_reg;

endmodule

// ### dv/adc_readout_properties.sv
// Purpose: port checks of the dual converter readout
// Assumes: pins move 6 cycles apart; outputs lag pins 3 to 5 cycles
// Notes:   bound into the top module
`timescale 1ns/100ps
module adc_readout_properties (
   input wire logic                          i_clock,
   input wire logic                          i_sys_rst,
   input wire logic                          i_cs_n,
   input wire logic                          i_sclk,
   input wire logic                          o_serial_out_a,
   input wire logic                          o_serial_out_a_oe_n,
   input wire logic                          o_serial_out_b,
   input wire logic                          o_serial_out_b_oe_n,
   input wire logic                          o_hold,
   input wire logic                          o_conv_start,
   input wire logic                          o_conv_abort,
   input wire logic                          o_conv_busy,
   input wire logic                          o_sar_step,
   input wire adc_readout_pkg::power_state_e o_power_state
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   // select fall followed by the start strobe
   sequence s_started;
      $fell(i_cs_n) ##[3:5] o_conv_start;
   endsequence
   a_select_drives: assert property (
      $fell(i_cs_n) |-> ##[3:5] (!o_serial_out_a_oe_n && !o_serial_out_b_oe_n
      && !o_serial_out_a && !o_serial_out_b)) else $error("lines not driven low");
   a_start_strobe: assert property ($fell(i_cs_n) |-> s_started)
      else $error("no start strobe");
   a_hold_kept: assert property (s_started |=> o_hold [*8])
      else $error("hold lost early");
   a_hold_release: assert property ($fell(o_hold) |-> (i_sclk || i_cs_n))
      else $error("track return off a rise");
   a_rise_floats: assert property ($rose(i_cs_n) |-> ##[3:5]
      (o_serial_out_a_oe_n && o_serial_out_b_oe_n && !o_hold)) else $error("no float");
   a_abort_strobe: assert property ($rose(i_cs_n) && o_conv_busy |-> ##[3:5] o_conv_abort)
      else $error("no abort");
   a_idle_floats: assert property (i_cs_n [*8] |-> o_serial_out_a_oe_n && o_serial_out_b_oe_n)
      else $error("line driven while idle");
   a_step_busy: assert property (o_sar_step |-> o_conv_busy)
      else $error("step outside conversion");
   a_full_entry: assert property ($changed(o_power_state) &&
      o_power_state == adc_readout_pkg::PWR_FULL |->
      $past(o_power_state) == adc_readout_pkg::PWR_PARTIAL) else $error("bad full entry");
endmodule
bind dual_adc_serial_readout adc_readout_properties chk (.*);

// ### dv/host_model.sv
// Purpose: host serial port and comparator stand-in
// Assumes: serial clock phases of 6 system cycles, idles high
// Notes:   captures each line just before making the next fall
`timescale 1ns/100ps
module host_model (
   input  wire logic i_clock,
   input  wire logic i_line_a,
   input  wire logic i_line_b,
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_dec_a,
   output logic      o_dec_b
);
   logic [31:0] cap_a; // bits seen on line a
   logic [31:0] cap_b; // bits seen on line b
   logic [31:0] cap_r; // line a as seen just before each rise
   initial begin
      o_cs_n = 1'h1;
      o_sclk = 1'h1;
      o_dec_a = 1'h0;
      o_dec_b = 1'h1;
   end
   // select low, then n serial clocks; outside result falls the bits toggle
   task automatic xfer(input int n, input logic [11:0] pa, input logic [11:0] pb);
      @(negedge i_clock) o_cs_n = 1'h0;
      repeat (6) @(negedge i_clock);
      for (int k = 1; k <= n; k++) begin
         cap_a = {cap_a[30:0], i_line_a};
         cap_b = {cap_b[30:0], i_line_b};
         o_sclk = 1'h0;
         o_dec_a = (k > 3 && k < 16) ? pa[15 - k] : ~o_dec_a;
         o_dec_b = (k > 3 && k < 16) ? pb[15 - k] : ~o_dec_b;
         repeat (6) @(negedge i_clock);
         cap_r = {cap_r[30:0], i_line_a};
         o_sclk = 1'h1;
         repeat (6) @(negedge i_clock);
      end
   endtask
   task automatic stop;
      @(negedge i_clock) o_cs_n = 1'h1;
      repeat (12) @(negedge i_clock);
   endtask
endmodule

// ### dv/testbench.sv
// Purpose: self-checking bench of the dual converter readout
// Assumes: inputs move on the falling clock edge
// Notes:   frames built here from the span, channel and result values
`timescale 1ns/100ps
module testbench;
   logic i_clock, i_sys_rst, i_cs_n, i_sclk, i_span_sel, i_channel_flag;
   logic i_decision_a, i_decision_b, o_serial_out_a, o_serial_out_a_oe_n;
   logic o_serial_out_b, o_serial_out_b_oe_n, o_hold, o_conv_start;
   logic o_conv_abort, o_conv_busy, o_sar_step;
   adc_readout_pkg::power_state_e o_power_state;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;
   dual_adc_serial_readout dut (.*);
   // a floated line shows the inverse of its last bit, so a missing drive shows up
   host_model host (.i_clock(i_clock), .i_line_a(o_serial_out_a ^ o_serial_out_a_oe_n),
      .i_line_b(o_serial_out_b ^ o_serial_out_b_oe_n), .o_cs_n(i_cs_n), .o_sclk(i_sclk),
      .o_dec_a(i_decision_a), .o_dec_b(i_decision_b));
   initial begin
      i_clock = 1'h0;
      forever #12.5 i_clock = ~i_clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         fail_count++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task give_verdict;
      if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic logic [15:0] frame(logic s, logic c, logic id, logic [11:0] r);
      return {1'h0, s, c, id, r};
   endfunction
   // first transfer: span bit still shows the reset value
   task normal_read;
      i_span_sel = 1'h1;
      host.xfer(16, 12'ha5c, 12'h3f1);
      check(host.cap_a[15:0], frame(1'h0, 1'h0, 1'h0, 12'ha5c));
      check(host.cap_b[15:0], frame(1'h0, 1'h0, 1'h1, 12'h3f1));
      check({1'h0, host.cap_r[15:1]}, frame(1'h0, 1'h0, 1'h0, 12'ha5c));
      check({o_hold, o_conv_busy}, 32'h0);
      host.stop();
   endtask
   // 32 clocks: each line carries the other converter next, then floats
   task ext_read;
      i_span_sel = 1'h0;
      i_channel_flag = 1'h1;
      host.xfer(32, 12'h0f7, 12'hc38);
      check(host.cap_a, {frame(1'h1, 1'h1, 1'h0, 12'h0f7), frame(1'h1, 1'h1, 1'h1, 12'hc38)});
      check(host.cap_b, {frame(1'h1, 1'h1, 1'h1, 12'hc38), frame(1'h1, 1'h1, 1'h0, 12'h0f7)});
      check({o_serial_out_a_oe_n, o_serial_out_b_oe_n}, 32'h3);
      host.stop();
   endtask
   // two early rises go partial then full; a long read wakes the part
   task power_modes;
      host.xfer(1, 12'h001, 12'h800);
      host.stop();
      check(o_power_state, adc_readout_pkg::PWR_NORMAL);
      host.xfer(5, 12'h001, 12'h800);
      host.stop();
      check(o_power_state, adc_readout_pkg::PWR_PARTIAL);
      host.xfer(5, 12'h001, 12'h800);
      host.stop();
      check(o_power_state, adc_readout_pkg::PWR_FULL);
      host.xfer(16, 12'h555, 12'haaa);
      check(o_power_state, adc_readout_pkg::PWR_NORMAL);
      host.stop();
      host.xfer(5, 12'h001, 12'h800);
      host.stop();
      check(o_power_state, adc_readout_pkg::PWR_PARTIAL);
      host.xfer(10, 12'h001, 12'h800);
      host.stop();
      check(o_power_state, adc_readout_pkg::PWR_NORMAL);
   endtask
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 10000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      i_sys_rst = 1'h1;
      i_span_sel = 1'h0;
      i_channel_flag = 1'h0;
      repeat (3) @(negedge i_clock);
      i_sys_rst = 1'h0;
      normal_read();
      ext_read();
      power_modes();
      give_verdict();
   end
endmodule
